// file: common/pic_pkg.sv
/*
 * Constants and carrier types for the prioritized interrupt and event transfer unit.
 * Assumes a 16-bit register port with word indices and a CPU that acknowledges
 * presented interrupts.
 */
package pic_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NSRC = 29;
  localparam int NCH  = 8;
  localparam int NEXT = 7;
  localparam int DW   = 16;
  localparam int AW   = 8;

  // ***************************************************************
  // Register indices
  // ***************************************************************
  localparam logic [7:0] A_SRC   = 8'h00;
  localparam logic [7:0] A_CH    = 8'h40;
  localparam logic [7:0] A_EDGE  = 8'h60;
  localparam logic [7:0] A_STS   = 8'h61;
  localparam logic [7:0] A_MASK  = 8'h62;
  localparam logic [7:0] A_STATE = 8'h63;

  // ***************************************************************
  // Fields
  // ***************************************************************
  localparam int F_LVL  = 0;
  localparam int F_EN   = 4;
  localparam int F_REQ  = 5;
  localparam int F_PEC  = 6;
  localparam int F_CH   = 7;
  localparam int C_WORD = 0;
  localparam int C_INCD = 1;
  localparam int C_CONT = 2;
  localparam int K_SRC  = 0;
  localparam int K_DST  = 1;
  localparam int K_CNT  = 2;
  localparam int K_CTL  = 3;

  // ***************************************************************
  // Reset values and fixed numbers
  // ***************************************************************
  localparam logic [15:0] PTR_RST  = 16'h0000;
  localparam logic [7:0]  CNT_RST  = 8'h00;
  localparam logic [13:0] EDGE_RST = 14'h0000;
  localparam logic [3:0]  TRAP_LVL = 4'hF;

  localparam logic [6:0] TRAP_NUM [NSRC] = '{
    7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
    7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29,
    7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F,
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45};

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic        word;
  } pic_xfer_t;

  typedef struct packed {
    logic [6:0] num;
    logic [8:0] vec;
    logic [3:0] lvl;
  } pic_int_t;

endpackage : pic_pkg

// file: design/pic_ctrl.sv
/*
 * Prioritized interrupt unit with an eight-channel event_transfer_engine.
 * Assumes one clock, synchronous inputs, a CPU that reports its running level
 * and pulses int_ack when it takes the presented interrupt, and a memory path
 * that performs the move offered on xfer in the cycle it is offered.
 */
// Our own choices: the strobed register port and the address map.
// What this block does
// R01: Accepted request is presented to the CPU two cycles after it arrives.
// R02: Each source selects vectored interrupt or event transfer service.
// R03: A transfer service is a single-cycle move with no vector branch.
// R04: Move byte or word, then bump source or destination pointer.
// R05: Each service decrements the channel counter unless continuous.
// R06: Counter reaching zero raises a standard interrupt of that source.
// R07: Eight channels, each with source pointer, destination pointer, counter.
// R08: Each source has request, enable and priority in its control register.
// R09: Priority field gives sixteen levels.
// R10: Only strictly higher enabled levels preempt the running service.
// R11: Each source owns a fixed distinct vector.
// R12: Fast inputs catch rising, falling or both edges as configured.
// R13: Software trap with a number selects the vector directly.
// R14: Software setting a request bit behaves like hardware.
// R15: Request bit clears when service is acknowledged or started.
// R16: Continuous mode leaves counter alone and raises no end interrupt.
`timescale 1ns/1ps
module pic_ctrl #(
  parameter int NSRC = pic_pkg::NSRC,
  parameter int NCH  = pic_pkg::NCH
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [pic_pkg::AW-1:0] addr,
  input  wire logic [pic_pkg::DW-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [pic_pkg::DW-1:0] rdata_ff,
  input  wire logic [NSRC-1:0]        hw_req,
  input  wire logic [pic_pkg::NEXT-1:0] ext_in,
  input  wire logic                   trap_req,
  input  wire logic [6:0]             trap_num,
  input  wire logic [3:0]             cpu_lvl,
  input  wire logic                   int_ack,
  output logic                        int_vld_ff,
  output pic_pkg::pic_int_t           int_ff,
  output logic                        xfer_vld_ff,
  output pic_pkg::pic_xfer_t          xfer_ff,
  output logic                        irq_ff
);

  localparam int SW = $clog2(NSRC);

  // ***************************************************************
  // Decode helpers
  // ***************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int k);
    hit = (a == base + 8'(k));
  endfunction : hit

  function automatic logic [15:0] step(input logic word);
    step = word ? 16'h0002 : 16'h0001;
  endfunction : step

  // ***************************************************************
  // State
  // ***************************************************************
  logic [3:0]            lvl_ff [NSRC];
  logic [2:0]            ch_ff  [NSRC];
  logic [NSRC-1:0]       en_ff;
  logic [NSRC-1:0]       req_ff;
  logic [NSRC-1:0]       pec_ff;
  logic [NSRC-1:0]       eob_ff;
  logic [15:0]           sp_ff  [NCH];
  logic [15:0]           dp_ff  [NCH];
  logic [7:0]            cnt_ff [NCH];
  logic [2:0]            ctl_ff [NCH];
  logic [13:0]           edge_ff;
  logic [pic_pkg::NEXT-1:0] ext_d_ff;
  logic [NCH-1:0]        sts_ff;
  logic [NCH-1:0]        mask_ff;
  logic                  trap_pend_ff;
  logic [6:0]            trap_num_ff;
  logic                  pres_trap_ff;
  logic [SW-1:0]         pres_idx_ff;

  logic [NSRC-1:0]       ext_hit;
  logic [NSRC-1:0]       svc_clr;
  logic [NSRC-1:0]       eob_set;
  logic [NCH-1:0]        nxt_sts;
  logic                  win_ok;
  logic [SW-1:0]         win_idx;
  logic [3:0]            win_lvl;
  logic [2:0]            win_ch;
  logic                  use_pec;
  logic                  pec_go;
  logic                  last_xfer;
  logic                  ack_src;
  logic [15:0]           rmux;

  // ***************************************************************
  // Fast external edge detection
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_d_ff <= '0;
    end else begin
      ext_d_ff <= ext_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_ff <= pic_pkg::EDGE_RST;
    end else if (wr && addr == pic_pkg::A_EDGE) begin
      edge_ff <= wdata[13:0];
    end
  end

  // Fast inputs feed sources 1..7; bit0 of a mode pair is rising, bit1 falling
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_ext
      if (g >= 1 && g <= pic_pkg::NEXT) begin : g_on
        assign ext_hit[g] = (edge_ff[2*g-2] & ext_in[g-1] & ~ext_d_ff[g-1])
                          | (edge_ff[2*g-1] & ~ext_in[g-1] & ext_d_ff[g-1]); // R12
      end else begin : g_off
        assign ext_hit[g] = 1'b0;
      end
    end
  endgenerate

  // ***************************************************************
  // Arbitration
  // ***************************************************************
  // Strict compare: ties go to the lower index, level 0 is never serviced
  always_comb begin
    win_ok  = 1'b0;
    win_idx = '0;
    win_lvl = cpu_lvl;
    for (int i = 0; i < NSRC; i++) begin
      if (req_ff[i] && en_ff[i] && lvl_ff[i] > win_lvl) begin // R10
        win_ok  = 1'b1;
        win_idx = SW'(i);
        win_lvl = lvl_ff[i];
      end
    end
  end

  assign win_ch    = ch_ff[win_idx];
  // Exhausted counter falls back to a vectored interrupt
  assign use_pec   = pec_ff[win_idx] & ~eob_ff[win_idx]
                   & (ctl_ff[win_ch][pic_pkg::C_CONT] | (cnt_ff[win_ch] != 8'h00)); // R02
  assign pec_go    = win_ok & use_pec;
  assign last_xfer = ~ctl_ff[win_ch][pic_pkg::C_CONT] & (cnt_ff[win_ch] == 8'h01); // R16
  assign ack_src   = int_ack & int_vld_ff & ~pres_trap_ff;

  // ***************************************************************
  // Per-source control registers
  // ***************************************************************
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      logic wsel;
      assign wsel = wr & hit(addr, pic_pkg::A_SRC, g);
      assign svc_clr[g] = (pec_go && win_idx == SW'(g))
                        | (ack_src && pres_idx_ff == SW'(g)); // R15
      assign eob_set[g] = pec_go && win_idx == SW'(g) && last_xfer; // R06

      always_ff @(posedge clk) begin
        if (rst) begin
          lvl_ff[g] <= 4'h0;
          ch_ff[g]  <= 3'h0;
          en_ff[g]  <= 1'b0;
          pec_ff[g] <= 1'b0;
        end else if (wsel) begin
          lvl_ff[g] <= wdata[pic_pkg::F_LVL +: 4]; // R09
          ch_ff[g]  <= wdata[pic_pkg::F_CH +: 3];
          en_ff[g]  <= wdata[pic_pkg::F_EN]; // R08
          pec_ff[g] <= wdata[pic_pkg::F_PEC]; // R02
        end
      end

      // Set wins over clear for every source of a request
      always_ff @(posedge clk) begin
        if (rst) begin
          req_ff[g] <= 1'b0;
        end else begin
          req_ff[g] <= (req_ff[g] & ~svc_clr[g] & ~(wsel & ~wdata[pic_pkg::F_REQ]))
                     | hw_req[g] | ext_hit[g] | eob_set[g]
                     | (wsel & wdata[pic_pkg::F_REQ]); // R14
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          eob_ff[g] <= 1'b0;
        end else begin
          eob_ff[g] <= eob_set[g] | (eob_ff[g] & ~(ack_src && pres_idx_ff == SW'(g)));
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Transfer channels
  // ***************************************************************
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic svc;
      logic [7:0] base;
      assign svc  = pec_go && win_ch == 3'(g);
      assign base = pic_pkg::A_CH + 8'(4 * g);

      always_ff @(posedge clk) begin
        if (rst) begin
          sp_ff[g]  <= pic_pkg::PTR_RST;
          dp_ff[g]  <= pic_pkg::PTR_RST;
          cnt_ff[g] <= pic_pkg::CNT_RST;
          ctl_ff[g] <= 3'h0;
        end else begin
          if (svc) begin
            if (ctl_ff[g][pic_pkg::C_INCD]) begin
              dp_ff[g] <= dp_ff[g] + step(ctl_ff[g][pic_pkg::C_WORD]); // R04
            end else begin
              sp_ff[g] <= sp_ff[g] + step(ctl_ff[g][pic_pkg::C_WORD]); // R04
            end
            if (!ctl_ff[g][pic_pkg::C_CONT]) begin
              cnt_ff[g] <= cnt_ff[g] - 8'h01; // R05
            end
          end
          // Software write lands after a same-cycle service
          if (wr && hit(addr, base, pic_pkg::K_SRC)) begin
            sp_ff[g] <= wdata;
          end
          if (wr && hit(addr, base, pic_pkg::K_DST)) begin
            dp_ff[g] <= wdata;
          end
          if (wr && hit(addr, base, pic_pkg::K_CNT)) begin
            cnt_ff[g] <= wdata[7:0];
          end
          if (wr && hit(addr, base, pic_pkg::K_CTL)) begin
            ctl_ff[g] <= wdata[2:0];
          end
        end
      end // R07
    end
  endgenerate

  // ***************************************************************
  // Transfer output
  // ***************************************************************
  // One pulse per service; the CPU loses exactly that cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_vld_ff <= 1'b0;
      xfer_ff     <= '0;
    end else begin
      xfer_vld_ff  <= pec_go; // R03
      xfer_ff.src  <= sp_ff[win_ch];
      xfer_ff.dst  <= dp_ff[win_ch];
      xfer_ff.word <= ctl_ff[win_ch][pic_pkg::C_WORD]; // R04
    end
  end

  // ***************************************************************
  // Software trap
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      trap_pend_ff <= 1'b0;
      trap_num_ff  <= 7'h00;
    end else begin
      trap_pend_ff <= trap_req | (trap_pend_ff & ~(int_ack & int_vld_ff & pres_trap_ff));
      if (trap_req) begin
        trap_num_ff <= trap_num; // R13
      end
    end
  end

  // ***************************************************************
  // Interrupt presentation
  // ***************************************************************
  // Withdrawn for one cycle after an ack so the old request is not re-offered
  always_ff @(posedge clk) begin
    if (rst) begin
      int_vld_ff   <= 1'b0;
      int_ff       <= '0;
      pres_trap_ff <= 1'b0;
      pres_idx_ff  <= '0;
    end else begin
      int_vld_ff   <= ~int_ack & (trap_pend_ff | (win_ok & ~use_pec)); // R01
      pres_trap_ff <= trap_pend_ff;
      if (trap_pend_ff) begin
        int_ff.num <= trap_num_ff; // R13
        int_ff.vec <= {trap_num_ff, 2'b00};
        int_ff.lvl <= pic_pkg::TRAP_LVL;
      end else begin
        pres_idx_ff <= win_idx;
        int_ff.num  <= pic_pkg::TRAP_NUM[win_idx]; // R11
        int_ff.vec  <= {pic_pkg::TRAP_NUM[win_idx], 2'b00}; // R11
        int_ff.lvl  <= win_lvl; // R10
      end
    end
  end

  // ***************************************************************
  // End-of-block status and interrupt line
  // ***************************************************************
  always_comb begin
    nxt_sts = sts_ff;
    if (wr && addr == pic_pkg::A_STS) begin
      nxt_sts = nxt_sts & ~wdata[NCH-1:0];
    end
    if (pec_go && last_xfer) begin
      nxt_sts[win_ch] = 1'b1; // R06
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sts_ff  <= '0;
      mask_ff <= '0;
      irq_ff  <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      if (wr && addr == pic_pkg::A_MASK) begin
        mask_ff <= wdata[NCH-1:0];
      end
      irq_ff <= |(nxt_sts & ((wr && addr == pic_pkg::A_MASK) ? wdata[NCH-1:0] : mask_ff));
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  always_comb begin
    rmux = 16'h0000;
    if (addr < pic_pkg::A_SRC + 8'(NSRC)) begin
      for (int i = 0; i < NSRC; i++) begin
        if (hit(addr, pic_pkg::A_SRC, i)) begin
          rmux[pic_pkg::F_LVL +: 4] = lvl_ff[i];
          rmux[pic_pkg::F_EN]       = en_ff[i];
          rmux[pic_pkg::F_REQ]      = req_ff[i];
          rmux[pic_pkg::F_PEC]      = pec_ff[i];
          rmux[pic_pkg::F_CH +: 3]  = ch_ff[i];
        end
      end
    end else if (addr >= pic_pkg::A_CH && addr < pic_pkg::A_CH + 8'(4 * NCH)) begin
      for (int c = 0; c < NCH; c++) begin
        if (hit(addr, pic_pkg::A_CH + 8'(4 * c), pic_pkg::K_SRC)) begin
          rmux = sp_ff[c];
        end
        if (hit(addr, pic_pkg::A_CH + 8'(4 * c), pic_pkg::K_DST)) begin
          rmux = dp_ff[c];
        end
        if (hit(addr, pic_pkg::A_CH + 8'(4 * c), pic_pkg::K_CNT)) begin
          rmux = {8'h00, cnt_ff[c]};
        end
        if (hit(addr, pic_pkg::A_CH + 8'(4 * c), pic_pkg::K_CTL)) begin
          rmux = {13'h0000, ctl_ff[c]};
        end
      end
    end else if (addr == pic_pkg::A_EDGE) begin
      rmux = {2'b00, edge_ff};
    end else if (addr == pic_pkg::A_STS) begin
      rmux = 16'(sts_ff);
    end else if (addr == pic_pkg::A_MASK) begin
      rmux = 16'(mask_ff);
    end else if (addr == pic_pkg::A_STATE) begin
      rmux = 16'({int_vld_ff, pres_trap_ff, trap_pend_ff, pres_idx_ff});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= rd ? rmux : 16'h0000;
    end
  end

endmodule : pic_ctrl

// file: sim/pic_ctrl_sva.sv
/* Concurrent checks on the pic_ctrl ports.
   Assumes a CPU that acknowledges only a presented interrupt. */
`timescale 1ns/1ps
module pic_ctrl_sva #(
  parameter int NSRC = pic_pkg::NSRC,
  parameter int NCH  = pic_pkg::NCH
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic [pic_pkg::AW-1:0]   addr,
  input wire logic [pic_pkg::DW-1:0]   wdata,
  input wire logic                     wr,
  input wire logic                     rd,
  input wire logic [pic_pkg::DW-1:0]   rdata_ff,
  input wire logic [NSRC-1:0]          hw_req,
  input wire logic [pic_pkg::NEXT-1:0] ext_in,
  input wire logic                     trap_req,
  input wire logic [6:0]               trap_num,
  input wire logic [3:0]               cpu_lvl,
  input wire logic                     int_ack,
  input wire logic                     int_vld_ff,
  input wire pic_pkg::pic_int_t        int_ff,
  input wire logic                     xfer_vld_ff,
  input wire pic_pkg::pic_xfer_t       xfer_ff,
  input wire logic                     irq_ff
);
  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_trap_taken;
    trap_req && !int_vld_ff ##1 !int_ack;
  endsequence
  sequence s_int_taken;
    int_ack && int_vld_ff;
  endsequence
  a_reset_quiet: assert property ($fell(rst) |->
    !int_vld_ff && !xfer_vld_ff && !irq_ff && rdata_ff == '0) else $error("busy after reset");
  a_rdata_idle: assert property (!rd |=> rdata_ff == '0) else $error("stray read data");
  a_ack_clears: assert property (s_int_taken |=> !int_vld_ff) else $error("ack ignored");
  a_trap_vector: assert property (s_trap_taken |=> int_vld_ff &&
    int_ff.num == $past(trap_num, 2) && int_ff.lvl == pic_pkg::TRAP_LVL) else $error("trap lost");
  a_vector_fixed: assert property (int_vld_ff |-> int_ff.vec == {int_ff.num, 2'b00})
    else $error("vector not four times number");
  a_level_nonzero: assert property (int_vld_ff |-> int_ff.lvl != 4'h0)
    else $error("level zero presented");
  a_level_above: assert property (int_vld_ff && int_ff.lvl != pic_pkg::TRAP_LVL |->
    int_ff.lvl > $past(cpu_lvl)) else $error("level not above running level");
  a_irq_cause: assert property ($rose(irq_ff) |->
    ($past(wr) && $past(addr) == pic_pkg::A_MASK) || xfer_vld_ff) else $error("irq rose");
endmodule : pic_ctrl_sva

bind pic_ctrl pic_ctrl_sva #(.NSRC(NSRC), .NCH(NCH)) pic_ctrl_sva_inst (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
  .hw_req(hw_req), .ext_in(ext_in), .trap_req(trap_req), .trap_num(trap_num),
  .cpu_lvl(cpu_lvl), .int_ack(int_ack), .int_vld_ff(int_vld_ff), .int_ff(int_ff),
  .xfer_vld_ff(xfer_vld_ff), .xfer_ff(xfer_ff), .irq_ff(irq_ff));

// file: sim/pic_cpu_model.sv
/* CPU model: takes each presented interrupt after a set delay.
   Assumes int_vld is the unit's registered presentation flag. */
`timescale 1ns/1ps
module pic_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       int_vld,
  input  wire logic [3:0] ack_dly,
  output logic            int_ack_ff = 1'b0
);
  // ***************************************************************
  // Model
  // ***************************************************************
  logic [3:0] wait_ff;
  logic       took_ff;
  // One ack per presentation; a long delay keeps the request standing
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff    <= 4'h0;
      took_ff    <= 1'b0;
      int_ack_ff <= 1'b0;
    end else begin
      int_ack_ff <= 1'b0;
      if (int_vld !== 1'b1) begin
        wait_ff <= 4'h0;
        took_ff <= 1'b0;
      end else if (!took_ff && wait_ff >= ack_dly) begin
        int_ack_ff <= 1'b1;
        took_ff    <= 1'b1;
      end else if (!took_ff) begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : pic_cpu_model

// file: sim/pic_ctrl_tb.sv
/* Directed testbench for pic_ctrl through its register port and request pins.
   Assumes the checker binds itself and the CPU model acknowledges interrupts. */
`timescale 1ns/1ps
module pic_ctrl_tb;
  logic                       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, trap_req = 1'b0;
  logic [7:0]                 addr = '0;
  logic [15:0]                wdata = '0, rdata;
  logic [pic_pkg::NSRC-1:0]   hw_req = '0;
  logic [6:0]                 ext_in = '0, trap_num = '0;
  logic [3:0]                 cpu_lvl = '0, ack_dly = 4'h1;
  logic                       int_ack, int_vld, xfer_vld, irq;
  pic_pkg::pic_int_t          int_info;
  pic_pkg::pic_xfer_t         xfer;
  int                         num_errors = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  pic_ctrl pic_ctrl_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata), .hw_req(hw_req), .ext_in(ext_in), .trap_req(trap_req),
    .trap_num(trap_num), .cpu_lvl(cpu_lvl), .int_ack(int_ack), .int_vld_ff(int_vld),
    .int_ff(int_info), .xfer_vld_ff(xfer_vld), .xfer_ff(xfer), .irq_ff(irq));
  pic_cpu_model pic_cpu_model_inst (.clk(clk), .rst(rst), .int_vld(int_vld),
    .ack_dly(ack_dly), .int_ack_ff(int_ack));
  // ***************************************************************
  // Stimulus
  // ***************************************************************
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic chk_val(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // Bounded wait; a miss ends the run at once
  task automatic wait_for(input bit sel, input logic lvl, input int lim);
    int n;
    n = 0;
    #1;
    while ((sel ? xfer_vld : int_vld) !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if ((sel ? xfer_vld : int_vld) !== lvl) begin
      num_errors++;
      $display("ERROR %0t wait timed out", $time);
      conclude();
    end
  endtask : wait_for
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_val(34'(rdata), 34'(e));
  endtask : reg_chk
  task automatic pulse(input logic [pic_pkg::NSRC-1:0] m);
    @(posedge clk);
    hw_req <= m;
    @(posedge clk);
    hw_req <= '0;
  endtask : pulse
  task automatic exp_int(input int i, input logic [3:0] l);
    wait_for(1'b0, 1'b1, 12);
    chk_val(34'({int_info.vec, int_info.lvl}), 34'({pic_pkg::TRAP_NUM[i], 2'b00, l}));
    wait_for(1'b0, 1'b0, 20);
  endtask : exp_int
  task automatic exp_xfer(input logic [15:0] s, input logic [15:0] d, input logic w);
    wait_for(1'b1, 1'b1, 12);
    chk_val({xfer, int_vld}, {s, d, w, 1'b0});
    @(posedge clk);
    #1;
    chk_val(34'(xfer_vld), 34'(0));
  endtask : exp_xfer
  task automatic no_int(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      seen = seen | int_vld;
    end
    chk_val(34'(seen), 34'(0));
  endtask : no_int
  task automatic set_pin(input logic v);
    @(posedge clk);
    ext_in[0] <= v;
  endtask : set_pin
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk_val(34'(irq), 34'(e));
  endtask : chk_irq
  task automatic setup_ch(input int c, input logic [15:0] s, d, n, ctl);
    reg_wr(pic_pkg::A_CH + 8'(4 * c + pic_pkg::K_SRC), s);
    reg_wr(pic_pkg::A_CH + 8'(4 * c + pic_pkg::K_DST), d);
    reg_wr(pic_pkg::A_CH + 8'(4 * c + pic_pkg::K_CNT), n);
    reg_wr(pic_pkg::A_CH + 8'(4 * c + pic_pkg::K_CTL), ctl);
  endtask : setup_ch
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    reg_chk(pic_pkg::A_SRC + 8'h09, 16'h0000);
    reg_chk(pic_pkg::A_CH + 8'h0E, 16'h0000);
    reg_wr(8'h70, 16'hFFFF);
    reg_chk(8'h70, 16'h0000);
    $display("test reset done");
    reg_wr(pic_pkg::A_SRC + 8'h09, 16'h0015);
    pulse(29'h0000_0200);
    exp_int(9, 4'h5);
    reg_chk(pic_pkg::A_SRC + 8'h09, 16'h0015);
    reg_wr(pic_pkg::A_SRC, 16'h0032);
    exp_int(0, 4'h2);
    $display("test vectored done");
    @(posedge clk);
    cpu_lvl <= 4'h7;
    ack_dly <= 4'h6;
    reg_wr(pic_pkg::A_SRC + 8'h0A, 16'h0017);
    reg_wr(pic_pkg::A_SRC + 8'h02, 16'h0013);
    reg_wr(pic_pkg::A_SRC + 8'h0B, 16'h001C);
    reg_wr(pic_pkg::A_SRC + 8'h0C, 16'h0010);
    pulse(29'h0000_1C04);
    exp_int(11, 4'hC);
    no_int(10);
    @(posedge clk);
    cpu_lvl <= 4'h0;
    exp_int(10, 4'h7);
    exp_int(2, 4'h3);
    no_int(10);
    $display("test priority done");
    @(posedge clk);
    cpu_lvl <= 4'hF;
    trap_req <= 1'b1;
    trap_num <= pic_pkg::TRAP_NUM[16];
    @(posedge clk);
    trap_req <= 1'b0;
    exp_int(16, 4'hF);
    @(posedge clk);
    cpu_lvl <= 4'h0;
    ack_dly <= 4'h1;
    $display("test trap done");
    reg_wr(pic_pkg::A_SRC + 8'h01, 16'h0014);
    for (int m = 0; m < 4; m++) begin
      reg_wr(pic_pkg::A_EDGE, 16'(m));
      set_pin(1'b1);
      if (m % 2 == 1) exp_int(1, 4'h4);
      else no_int(8);
      set_pin(1'b0);
      if (m >= 2) exp_int(1, 4'h4);
      else no_int(8);
    end
    $display("test edges done");
    setup_ch(3, 16'h1000, 16'h2000, 16'h0002, 16'h0003);
    reg_wr(pic_pkg::A_SRC + 8'h13, 16'h01D6);
    pulse(29'h0008_0000);
    exp_xfer(16'h1000, 16'h2000, 1'b1);
    pulse(29'h0008_0000);
    exp_xfer(16'h1000, 16'h2002, 1'b1);
    exp_int(19, 4'h6);
    reg_chk(pic_pkg::A_CH + 8'h0E, 16'h0000);
    reg_chk(pic_pkg::A_CH + 8'h0D, 16'h2004);
    reg_chk(pic_pkg::A_STS, 16'h0008);
    chk_irq(1'b0);
    reg_wr(pic_pkg::A_MASK, 16'h0008);
    chk_irq(1'b1);
    reg_wr(pic_pkg::A_STS, 16'h0008);
    chk_irq(1'b0);
    setup_ch(5, 16'h0300, 16'h0400, 16'h0001, 16'h0004);
    reg_wr(pic_pkg::A_SRC + 8'h14, 16'h02D6);
    pulse(29'h0010_0000);
    exp_xfer(16'h0300, 16'h0400, 1'b0);
    pulse(29'h0010_0000);
    exp_xfer(16'h0301, 16'h0400, 1'b0);
    no_int(10);
    reg_chk(pic_pkg::A_CH + 8'h16, 16'h0001);
    reg_chk(pic_pkg::A_STS, 16'h0000);
    setup_ch(3, 16'h1000, 16'h2000, 16'h0001, 16'h0001);
    pulse(29'h0008_0000);
    exp_xfer(16'h1000, 16'h2000, 1'b1);
    exp_int(19, 4'h6);
    chk_irq(1'b1);
    reg_chk(pic_pkg::A_STS, 16'h0008);
    $display("test transfer done");
    conclude();
  end
endmodule : pic_ctrl_tb
